/* File: src/acs_pkg.sv */
package acs_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned PERIOD_SHIFT = 10;          // 1024 clocks per filter word step
  localparam int unsigned CNT_W        = 20;          // 1024 x 1023 fits in 20 bits

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_MODE    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQ_ST  = 8'h08;
  localparam logic [7:0] A_IRQ_MSK = 8'h0c;
  localparam logic [7:0] A_DATA    = 8'h10;
  localparam logic [7:0] A_OFS     = 8'h14;
  localparam logic [7:0] A_FSC     = 8'h18;

  // ---------------------------------------------------------------
  // Mode and status register fields
  // ---------------------------------------------------------------
  localparam int unsigned FRW_LSB    = 0;
  localparam int unsigned CLKDIV_BIT = 13;
  localparam int unsigned CHOP_BIT   = 14;
  localparam int unsigned SINC3_BIT  = 15;
  localparam int unsigned GAIN_LSB   = 16;
  localparam int unsigned OPM_LSB    = 21;
  localparam int unsigned STAT_RDY_BIT  = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;

  // Operating mode codes
  localparam logic [2:0] OPM_CONT     = 3'h0;
  localparam logic [2:0] OPM_SINGLE   = 3'h1;
  localparam logic [2:0] OPM_IDLE     = 3'h2;
  localparam logic [2:0] OPM_PDOWN    = 3'h3;
  localparam logic [2:0] OPM_INT_ZERO = 3'h4;
  localparam logic [2:0] OPM_INT_FULL = 3'h5;
  localparam logic [2:0] OPM_SYS_ZERO = 3'h6;
  localparam logic [2:0] OPM_SYS_FULL = 3'h7;

  localparam logic [2:0] GAIN_ONE = 3'h0;

  // Converter input routing
  localparam logic [1:0] REF_EXT  = 2'h0;
  localparam logic [1:0] REF_ZERO = 2'h1;
  localparam logic [1:0] REF_FULL = 2'h2;

  // Settling time in output periods
  localparam logic [4:0] SETTLE_SINC4 = 5'h04;
  localparam logic [4:0] SETTLE_SINC3 = 5'h03;
  localparam logic [4:0] SETTLE_CHOP  = 5'h02;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [9:0]  FRW_RST = 10'h060;
  localparam logic [23:0] OFS_RST = 24'h800000;
  localparam logic [23:0] FSC_RST = 24'h800000;
  localparam int unsigned FSC_SHIFT = 23;             // 0x800000 is unity gain
  localparam logic [23:0] MID_CODE  = 24'h800000;

  // Interrupt bits
  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IRQ_CONV   = 0;
  localparam int unsigned IRQ_CAL    = 1;
  localparam int unsigned IRQ_REFUSE = 2;

  typedef enum logic {CAL_IDLE, CAL_RUN} acs_cal_t;

endpackage : acs_pkg

/* File: src/acs_scale.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_scale
  import acs_pkg::*;
(
  input  wire logic        pclk,      // Clock
  input  wire logic        presetn,   // Async reset, low
  input  wire logic        in_valid,  // Raw result strobe
  input  wire logic [23:0] raw,       // Raw result, offset binary
  input  wire logic [23:0] ofs,       // Offset coefficient
  input  wire logic [23:0] fsc,       // Full-scale coefficient
  output logic             out_valid, // Scaled result strobe
  output logic [23:0]      out_data   // Scaled result
);

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } acs_scale_st_t;

  acs_scale_st_t        r;
  acs_scale_st_t        n;
  logic signed [24:0]   diff;
  logic signed [49:0]   prod;
  logic signed [49:0]   shf;

  always_comb begin
    n       = r;
    diff    = $signed({1'b0, raw}) - $signed({1'b0, ofs});
    // Widen both factors first so the product is formed at full width
    prod    = 50'(diff) * 50'($signed({1'b0, fsc}));
    shf     = prod >>> FSC_SHIFT;
    n.valid = in_valid;
    if (in_valid) begin
      // Saturate instead of wrapping so an overrange input cannot fold back
      if (shf > 50'sh7fffff) begin
        n.data = 24'hffffff;
      end else if (shf < -50'sh800000) begin
        n.data = 24'h000000;
      end else begin
        n.data = {~shf[23], shf[22:0]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign out_valid = r.valid;
  assign out_data  = r.data;

endmodule : acs_scale
`default_nettype wire

/* File: src/acs_cal_seq.sv */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acs_cal_seq
  import acs_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  input  wire logic              pclk,       // APB clock, also master clock
  input  wire logic              presetn,    // Async reset, low
  input  wire logic              psel,       // APB select
  input  wire logic              penable,    // APB enable
  input  wire logic              pwrite,     // APB direction
  input  wire logic [ADDR_W-1:0] paddr,      // APB byte address
  input  wire logic [31:0]       pwdata,     // APB write data
  output logic [31:0]            prdata,     // APB read data
  output logic                   pready,     // APB ready
  output logic                   pslverr,    // APB error
  input  wire logic              conv_valid, // Raw result strobe from filter
  input  wire logic [23:0]       conv_raw,   // Raw filter result
  input  wire logic              cs_n_pin,   // Chip select pin, low active
  output logic                   rdy_pin_n,  // Data-out/ready pin level, low = ready
  output logic                   rdy_pin_oe, // Ready pin driven
  output logic [1:0]             ref_sel,    // Converter input routing
  output logic                   irq         // Level interrupt
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             cs_meta;
    logic             cs_sync;
    logic [2:0]       opm;
    logic [9:0]       frw;
    logic             clkdiv;
    logic             chop;
    logic             sinc3;
    logic [2:0]       gain;
    acs_cal_t         cal_st;
    logic [2:0]       cal_kind;
    logic [CNT_W-1:0] tmr;
    logic [4:0]       per_cnt;
    logic [4:0]       per_tgt;
    logic [23:0]      cal_smp;
    logic [1:0]       ref_sel;
    logic [23:0]      ofs;
    logic [23:0]      fsc;
    logic [23:0]      data;
    logic             rdy_n;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;
    logic [31:0]      prdata;
    logic             pin_n;
    logic             pin_oe;
    logic             irq;
  } acs_state_t;

  acs_state_t        r;
  acs_state_t        n;
  logic              acc;
  logic              setup;
  logic              wr_acc;
  logic              rd_acc;
  logic              addr_ok;
  logic              coef_ok;
  logic              coef_wr;
  logic              tick;
  logic [9:0]        frw_eff;
  logic [CNT_W-1:0]  per_len;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  clr;
  logic [2:0]        wopm;
  logic              sc_in;
  logic              sc_valid;
  logic [23:0]       sc_data;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_cal(input logic [2:0] m);
    return m[2];
  endfunction : is_cal

  function automatic logic [4:0] settle_periods(input logic [2:0] kind,
                                                input logic       chop,
                                                input logic       sinc3,
                                                input logic [2:0] gain,
                                                input logic       clkdiv);
    logic [4:0] p;
    p = chop ? SETTLE_CHOP : (sinc3 ? SETTLE_SINC3 : SETTLE_SINC4);
    if (kind == OPM_INT_FULL) begin
      if (gain != GAIN_ONE) begin
        p = 5'(p << 1);
      end
      if (clkdiv) begin
        p = 5'(p << 1);
      end
    end
    return p;
  endfunction : settle_periods

  function automatic logic [1:0] route_for(input logic [2:0] kind);
    case (kind)
      OPM_INT_ZERO: return REF_ZERO;
      OPM_INT_FULL: return REF_FULL;
      default:      return REF_EXT;
    endcase
  endfunction : route_for

  // ---------------------------------------------------------------
  // Result scaling
  // ---------------------------------------------------------------
  assign sc_in = conv_valid && (r.cal_st == CAL_IDLE) &&
                 ((r.opm == OPM_CONT) || (r.opm == OPM_SINGLE));

  acs_scale u_scale (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (sc_in),
    .raw       (conv_raw),
    .ofs       (r.ofs),
    .fsc       (r.fsc),
    .out_valid (sc_valid),
    .out_data  (sc_data)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign acc     = psel && penable;
  assign setup   = psel && !penable;
  assign wr_acc  = acc && pwrite;
  assign rd_acc  = acc && !pwrite;
  assign addr_ok = (paddr == A_MODE)    || (paddr == A_STATUS) ||
                   (paddr == A_IRQ_ST)  || (paddr == A_IRQ_MSK) ||
                   (paddr == A_DATA)    || (paddr == A_OFS) ||
                   (paddr == A_FSC);
  assign coef_ok = ((r.opm == OPM_IDLE) || (r.opm == OPM_PDOWN)) &&
                   (r.cal_st == CAL_IDLE);
  assign coef_wr = wr_acc && ((paddr == A_OFS) || (paddr == A_FSC));
  assign pready  = 1'b1;
  assign pslverr = acc && (!addr_ok || (coef_wr && !coef_ok));
  assign wopm    = pwdata[OPM_LSB +: 3];
  assign frw_eff = (r.frw == 10'h000) ? 10'h001 : r.frw;
  assign per_len = CNT_W'({10'h000, frw_eff} << PERIOD_SHIFT);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n         = r;
    tick      = 1'b0;
    ev        = '0;
    clr       = '0;
    n.cs_meta = cs_n_pin;
    n.cs_sync = r.cs_meta;

    // Output period timer only runs while calibrating
    if (r.cal_st == CAL_RUN) begin
      if (r.tmr == per_len - CNT_W'(1)) begin
        n.tmr = '0;
        tick  = 1'b1;
      end else begin
        n.tmr = r.tmr + CNT_W'(1);
      end
      if (conv_valid) begin
        n.cal_smp = conv_raw;
      end
    end

    // Reading the data clears the ready indication
    if (rd_acc && (paddr == A_DATA)) begin
      n.rdy_n = 1'b1;
    end

    // Calibration completion
    if (tick) begin
      n.per_cnt = r.per_cnt + 5'h01;
      if (r.per_cnt + 5'h01 == r.per_tgt) begin
        if ((r.cal_kind == OPM_INT_ZERO) || (r.cal_kind == OPM_SYS_ZERO)) begin
          n.ofs = n.cal_smp;
        end else begin
          n.fsc = n.cal_smp;
        end
        n.cal_st      = CAL_IDLE;
        n.opm         = OPM_IDLE;
        n.ref_sel     = REF_EXT;
        n.rdy_n       = 1'b0;
        ev[IRQ_CAL]   = 1'b1;
      end
    end

    // Normal conversion result
    if (sc_valid && (r.cal_st == CAL_IDLE) &&
        ((r.opm == OPM_CONT) || (r.opm == OPM_SINGLE))) begin
      n.data       = sc_data;
      n.rdy_n      = 1'b0;
      ev[IRQ_CONV] = 1'b1;
      if (r.opm == OPM_SINGLE) begin
        n.opm = OPM_IDLE;
      end
    end

    // Register writes
    if (wr_acc) begin
      case (paddr)
        A_MODE: begin
          n.frw    = pwdata[FRW_LSB +: 10];
          n.clkdiv = pwdata[CLKDIV_BIT];
          n.chop   = pwdata[CHOP_BIT];
          n.sinc3  = pwdata[SINC3_BIT];
          n.gain   = pwdata[GAIN_LSB +: 3];
          n.opm    = wopm;
          if (is_cal(wopm)) begin
            // A new code restarts any calibration already running
            n.cal_st   = CAL_RUN;
            n.cal_kind = wopm;
            n.tmr      = '0;
            n.per_cnt  = '0;
            n.per_tgt  = settle_periods(wopm, pwdata[CHOP_BIT], pwdata[SINC3_BIT],
                                        pwdata[GAIN_LSB +: 3], pwdata[CLKDIV_BIT]);
            n.ref_sel  = route_for(wopm);
            n.cal_smp  = conv_raw;
            n.rdy_n    = 1'b1;
          end else begin
            n.cal_st  = CAL_IDLE;
            n.ref_sel = REF_EXT;
          end
        end
        A_IRQ_ST: begin
          clr = pwdata[IRQ_W-1:0];
        end
        A_IRQ_MSK: begin
          n.irq_msk = pwdata[IRQ_W-1:0];
        end
        A_OFS: begin
          if (coef_ok) begin
            n.ofs = pwdata[23:0];
          end else begin
            ev[IRQ_REFUSE] = 1'b1;
          end
        end
        A_FSC: begin
          if (coef_ok) begin
            n.fsc = pwdata[23:0];
          end else begin
            ev[IRQ_REFUSE] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // New events beat a clear in the same cycle
    n.irq_st = (r.irq_st & ~clr) | ev;

    // Read data is captured in the setup cycle
    if (setup && !pwrite) begin
      case (paddr)
        A_MODE:    n.prdata = {8'h00, r.opm, 2'h0, r.gain, r.sinc3, r.chop, r.clkdiv,
                               3'h0, r.frw};
        A_STATUS:  n.prdata = {30'h0, (r.cal_st == CAL_RUN), r.rdy_n};
        A_IRQ_ST:  n.prdata = {{(32-IRQ_W){1'b0}}, r.irq_st};
        A_IRQ_MSK: n.prdata = {{(32-IRQ_W){1'b0}}, r.irq_msk};
        A_DATA:    n.prdata = {8'h00, r.data};
        A_OFS:     n.prdata = {8'h00, r.ofs};
        A_FSC:     n.prdata = {8'h00, r.fsc};
        default:   n.prdata = 32'h0;
      endcase
    end

    // Ready pin follows the ready bit only while selected
    n.pin_oe = !r.cs_sync;
    n.pin_n  = r.cs_sync ? 1'b1 : n.rdy_n;
    n.irq    = |(n.irq_st & n.irq_msk);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.cs_meta <= 1'b1;
      r.cs_sync <= 1'b1;
      r.opm     <= OPM_CONT;
      r.frw     <= FRW_RST;
      r.cal_st  <= CAL_IDLE;
      r.ref_sel <= REF_EXT;
      r.ofs     <= OFS_RST;
      r.fsc     <= FSC_RST;
      r.rdy_n   <= 1'b1;
      r.pin_n   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata     = r.prdata;
  assign rdy_pin_n  = r.pin_n;
  assign rdy_pin_oe = r.pin_oe;
  assign ref_sel    = r.ref_sel;
  assign irq        = r.irq;

endmodule : acs_cal_seq
`default_nettype wire

/* File: tb/acs_cal_seq_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_cal_seq_sva
  import acs_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)
(
  input wire logic              pclk,       // Clock
  input wire logic              presetn,    // Reset, low
  input wire logic              psel,       // Select
  input wire logic              penable,    // Enable
  input wire logic              pwrite,     // Direction
  input wire logic [ADDR_W-1:0] paddr,      // Address
  input wire logic [31:0]       pwdata,     // Write data
  input wire logic [31:0]       prdata,     // Read data
  input wire logic              pready,     // Ready
  input wire logic              pslverr,    // Error
  input wire logic              conv_valid, // Raw strobe
  input wire logic [23:0]       conv_raw,   // Raw result
  input wire logic              cs_n_pin,   // Chip select, low
  input wire logic              rdy_pin_n,  // Ready pin
  input wire logic              rdy_pin_oe, // Ready pin driven
  input wire logic [1:0]        ref_sel,    // Input routing
  input wire logic              irq         // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  logic mode_wr;
  logic unmap;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign mode_wr = wr && paddr == A_MODE;
  assign unmap   = paddr[1:0] != 2'h0 || paddr > A_FSC;

  apb_ready_a: assert property (acc |-> pready) else $error("pready low in access");
  unmapped_err_a: assert property (acc && unmap |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  idle_err_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  zero_ref_a: assert property (mode_wr && pwdata[23:21] == OPM_INT_ZERO |=> ref_sel == REF_ZERO)
    else $error("zero reference not routed");
  full_ref_a: assert property (mode_wr && pwdata[23:21] == OPM_INT_FULL |=> ref_sel == REF_FULL)
    else $error("full-scale reference not routed");
  sys_ref_a: assert property (mode_wr && pwdata[23:22] == 2'h3 |=> ref_sel == REF_EXT)
    else $error("system calibration not on pins");
  start_pin_a: assert property (mode_wr && pwdata[23] && rdy_pin_oe |-> ##2 rdy_pin_n)
    else $error("ready pin not high at start");
  done_pin_a: assert property ((ref_sel != REF_EXT && !wr) ##1 (ref_sel == REF_EXT && rdy_pin_oe)
    |=> !rdy_pin_n) else $error("ready pin not low at end");
  oe_on_a: assert property (!cs_n_pin [*4] |-> rdy_pin_oe) else $error("pin not driven");
  oe_off_a: assert property (cs_n_pin [*4] |-> !rdy_pin_oe) else $error("pin driven unselected");
  mask_off_a: assert property (wr && paddr == A_IRQ_MSK && pwdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq high with all masked");

  cover property (mode_wr && pwdata[23:21] == OPM_INT_FULL);
  cover property (acc && pslverr);
  cover property (ref_sel != REF_EXT ##1 ref_sel == REF_EXT);
endmodule : acs_cal_seq_sva
`default_nettype wire

/* File: tb/acs_conv_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_conv_model
(
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Reset, low
  input  wire logic [23:0] level,      // Applied input, offset binary
  output logic             conv_valid, // Result strobe
  output logic [23:0]      conv_raw    // Result
);
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 8'h00;
      conv_valid <= 1'b0;
      conv_raw   <= 24'h000000;
    end else begin
      cnt_q      <= (cnt_q == 8'hc7) ? 8'h00 : cnt_q + 8'h01;
      conv_valid <= cnt_q == 8'hc7;
      // Off-strobe value is garbage so a stale sample shows up
      conv_raw   <= (cnt_q == 8'hc7) ? level : ~level;
    end
  end
endmodule : acs_conv_model
`default_nettype wire

/* File: tb/test_adc_calibration_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_adc_calibration_sequencer;
  import acs_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_valid;
  logic [23:0] conv_raw;
  logic        cs_n_pin = 1'b1;
  logic        rdy_pin_n;
  logic [1:0]  ref_sel;
  logic        irq;
  logic [23:0] level = 24'h800300;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #20 pclk = ~pclk;

  acs_cal_seq #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid), .conv_raw(conv_raw),
    .cs_n_pin(cs_n_pin), .rdy_pin_n(rdy_pin_n), .rdy_pin_oe(), .ref_sel(ref_sel), .irq(irq));
  acs_conv_model model (.pclk(pclk), .presetn(presetn), .level(level),
    .conv_valid(conv_valid), .conv_raw(conv_raw));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   k;
    logic rdy_s;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      // Mid-cycle sample gives the values that stand at the coming edge
      @(negedge pclk);
      rdy_s = pready;
      rd    = prdata;
      err   = pslverr;
      @(posedge pclk);
      if (rdy_s === 1'b1) break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      n_mismatch++;
      final_report();
    end
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rchk

  // Period is frw x 1024 clocks; pin falls on the done edge, seen mid-cycle after it
  task automatic run_cal(input logic [2:0] op, input logic [9:0] frw, input logic chop,
                         input logic sinc3, input logic [2:0] gain, input int p,
                         input logic [23:0] lv);
    logic [31:0] m;
    int          k;
    m = {8'h00, op, 2'h0, gain, sinc3, chop, 1'b0, 3'h0, frw};
    level <= lv;
    apb(1'b1, A_MODE, m);
    for (k = 1; k < 70000; k++) begin
      @(negedge pclk);
      if (k == 3) chk("pin_start", 32'h1, {31'h0, rdy_pin_n});
      if (k > 3 && rdy_pin_n === 1'b0) break;
    end
    if (k == 70000) begin
      n_mismatch++;
      final_report();
    end
    chk("cal_cycles", 32'(p * int'(frw) * 1024 + 1), 32'(k));
    rchk(A_STATUS, 32'h0, "status_done");
    rchk(A_MODE, {m[31:24], OPM_IDLE, m[20:0]}, "mode_idle");
    rchk(op[0] ? A_FSC : A_OFS, {8'h00, lv}, "coef");
    rchk(A_DATA, 32'h00800300, "data_held");
    chk("irq_cal", 32'h1, {31'h0, irq});
    apb(1'b1, A_IRQ_ST, 32'h2);
  endtask : run_cal

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_MODE, 32'h00000060, "mode_rst");
    rchk(A_STATUS, 32'h1, "status_rst");
    rchk(A_OFS, 32'h00800000, "ofs_rst");
    rchk(A_FSC, 32'h00800000, "fsc_rst");
    rchk(8'h40, 32'h0, "unmapped");
    chk("unmapped_err", 32'h1, {31'h0, err});
    cs_n_pin <= 1'b0;
    apb(1'b1, A_IRQ_MSK, 32'h7);
    repeat (300) @(posedge pclk);
    rchk(A_DATA, 32'h00800300, "data_unity");
    chk("irq_conv", 32'h1, {31'h0, irq});
    apb(1'b1, A_IRQ_MSK, 32'h0);
    repeat (3) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, A_OFS, 32'h00123456);
    chk("ofs_refused", 32'h1, {31'h0, err});
    rchk(A_OFS, 32'h00800000, "ofs_kept");
    apb(1'b0, A_IRQ_ST, 32'h0);
    chk("irq_refuse", 32'h4, rd & 32'h4);
    apb(1'b1, A_IRQ_ST, 32'h7);
    apb(1'b1, A_IRQ_MSK, 32'h2);
    // Idle first so no conversion lands in DATA while the input level moves
    apb(1'b1, A_MODE, {8'h00, OPM_IDLE, 21'h000060});
    run_cal(OPM_INT_ZERO, 10'h001, 1'b0, 1'b0, GAIN_ONE, 4, 24'h800010);
    run_cal(OPM_SYS_ZERO, 10'h001, 1'b0, 1'b1, 3'h3, 3, 24'h800020);
    run_cal(OPM_INT_ZERO, 10'h001, 1'b1, 1'b0, GAIN_ONE, 2, 24'h800030);
    run_cal(OPM_SYS_FULL, 10'h001, 1'b0, 1'b0, 3'h2, 4, 24'h7ff000);
    run_cal(OPM_INT_FULL, 10'h010, 1'b1, 1'b0, 3'h1, 4, 24'h7ff800);
    apb(1'b1, A_OFS, 32'h00800100);
    chk("ofs_wr_err", 32'h0, {31'h0, err});
    apb(1'b1, A_FSC, 32'h00400000);
    rchk(A_FSC, 32'h00400000, "fsc_wr");
    level <= 24'h800300;
    apb(1'b1, A_MODE, 32'h00000001);
    repeat (300) @(posedge pclk);
    rchk(A_DATA, 32'h00800100, "data_scaled");
    final_report();
  end
endmodule : test_adc_calibration_sequencer

bind acs_cal_seq acs_cal_seq_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
  .conv_raw(conv_raw), .cs_n_pin(cs_n_pin), .rdy_pin_n(rdy_pin_n), .rdy_pin_oe(rdy_pin_oe),
  .ref_sel(ref_sel), .irq(irq));
`default_nettype wire
